// file: common/pcg_consts.svh
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

`define PCG_OFF_CTL 32'h0000005C
`define PCG_OFF_BWC 32'h0000005D
`define PCG_OFF_PRG 32'h0000005E

`define PCG_ADDR_CTL 12'h170
`define PCG_ADDR_BWC 12'h174
`define PCG_ADDR_PRG 12'h178

`define PCG_CTL_IE    7
`define PCG_CTL_FLAG  6
`define PCG_CTL_ON    5
`define PCG_CTL_BCS   4
`define PCG_BWC_AUTO  7
`define PCG_BWC_LOCK  6
`define PCG_BWC_TRK   5
`define PCG_BWC_XLD   4

`define PCG_MUL_RST   4'h6
`define PCG_VRS_RST   4'h6
`define PCG_CTL_LOW   4'hF

`define PCG_SW_CYC    3'h3

`endif

// file: common/pcg_pkg.sv
`default_nettype none
package pcg_pkg;
	typedef enum logic [1:0] {
		PCG_ST_RUN  = 2'h0,
		PCG_ST_XHLD = 2'h1,
		PCG_ST_VHLD = 2'h3
	} pcg_sw_e;
	typedef logic [3:0] pcg_nib_t;
endpackage
`default_nettype wire

// file: logic/pcg_regs.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.svh"
module pcg_regs
	import pcg_pkg::*;
(
	// system
	input  wire logic        clock,
	input  wire logic        rst,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output var  logic [1:0]  s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	// pll analog side
	input  wire logic        pll_lock_in,
	input  wire logic        pll_track_in,
	input  wire logic        crystal_active,
	input  wire logic        crystal_clock,
	input  wire logic        vco_clock,
	output var  logic        pll_enable,
	output var  logic        pll_auto_bw,
	output var  logic        pll_tracking,
	output var  logic [3:0]  feedback_ratio,
	output var  logic [3:0]  vco_range_select,
	// clock and interrupt
	output var  logic        base_clock_out,
	output var  logic        lock_irq
);

	typedef struct packed {
		logic        aw_got;
		logic [11:0] aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic        rvalid;
		logic [31:0] rdata;
		logic        ie;
		logic        flag;
		logic        on;
		logic        base_clock_select;
		logic        auto_bw;
		logic        trk_man;
		logic        crystal_loss_detect;
		logic        lock_q;
		pcg_nib_t    mul;
		pcg_nib_t    vrs;
		pcg_sw_e     sw;
		logic [2:0]  sw_cnt;
		logic        src_sel;
		logic        xc_q;
		logic        vc_q;
		logic        div;
		logic        irq;
		logic        awrdy;
		logic        wrdy;
		logic        arrdy;
		logic        en;
		pcg_nib_t    ratio;
	} pcg_state_s;

	pcg_state_s s_r;
	pcg_state_s s_nxt;

	// effective multiplier, zero treated as one
	function automatic pcg_nib_t pcg_mul_eff(input pcg_nib_t m);
		pcg_mul_eff = (m == 4'h0) ? 4'h1 : m;
	endfunction

	function automatic logic [7:0] pcg_ctl_val(input pcg_state_s s);
		logic ie_v;
		logic fl_v;
		ie_v = s.ie & s.auto_bw;
		fl_v = s.flag & s.auto_bw;
		pcg_ctl_val = {ie_v, fl_v, s.on, s.base_clock_select, `PCG_CTL_LOW};
	endfunction

	function automatic logic [7:0] pcg_bwc_val(input pcg_state_s s);
		logic lk;
		logic tk;
		lk = s.auto_bw & s.lock_q;
		tk = s.auto_bw ? pll_track_in : s.trk_man;
		pcg_bwc_val = {s.auto_bw, lk, tk, s.crystal_loss_detect & s.base_clock_select, 4'h0};
	endfunction

	logic       wr_go;
	logic       rd_go;
	logic [7:0] wb;
	logic       xc_edge;
	logic       vc_edge;

	always_comb begin
		s_nxt = s_r;
		wb = 8'h00;
		// address and data taken independently, answered when both held
		if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
		rd_go = s_axi_arvalid && !s_r.rvalid;
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;

		// lock toggle tracking
		s_nxt.lock_q = pll_lock_in;
		if (s_r.auto_bw && (pll_lock_in != s_r.lock_q))
			s_nxt.flag = 1'b1;

		// read: a CTL read clears the flag unless a toggle lands now
		if (rd_go) begin
			s_nxt.rvalid = 1'b1;
			case (s_axi_araddr[11:2])
			10'(`PCG_OFF_CTL): begin
				s_nxt.rdata = {24'h0, pcg_ctl_val(s_r)};
				if (!(s_r.auto_bw && (pll_lock_in != s_r.lock_q)))
					s_nxt.flag = 1'b0;
			end
			10'(`PCG_OFF_BWC):
				s_nxt.rdata = {24'h0, pcg_bwc_val(s_r)};
			10'(`PCG_OFF_PRG):
				s_nxt.rdata = {24'h0, s_r.mul, s_r.vrs};
			default:
				s_nxt.rdata = 32'h00000000;
			endcase
		end

		if (wr_go) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			wb = s_r.w_data[7:0];
			if (s_r.w_strb[0]) begin
				case (s_r.aw_addr[11:2])
				10'(`PCG_OFF_CTL): begin
					if (s_r.auto_bw)
						s_nxt.ie = wb[`PCG_CTL_IE];
					// clear refused while selected, others still land
					if (!s_r.base_clock_select)
						s_nxt.on = wb[`PCG_CTL_ON];
					// select only from an already-on state
					if (s_r.on && s_r.vrs != 4'h0)
						s_nxt.base_clock_select = wb[`PCG_CTL_BCS];
					else if (!wb[`PCG_CTL_BCS])
						s_nxt.base_clock_select = 1'b0;
				end
				10'(`PCG_OFF_BWC): begin
					s_nxt.auto_bw = wb[`PCG_BWC_AUTO];
					// saved value untouched while auto runs
					if (!s_r.auto_bw)
						s_nxt.trk_man = wb[`PCG_BWC_TRK];
					if (wb[`PCG_BWC_XLD])
						s_nxt.crystal_loss_detect = 1'b0;
				end
				10'(`PCG_OFF_PRG): begin
					if (!s_r.on) begin
						s_nxt.mul = wb[7:4];
						s_nxt.vrs = wb[3:0];
					end
				end
				default: ;
				endcase
			end
		end
		if (!s_nxt.auto_bw)
			s_nxt.ie = 1'b0;

		// crystal loss: each XLD write while selected sets it if crystal_active is low, else clears it; deselect clears it
		if (s_r.base_clock_select && !crystal_active && wr_go && s_r.w_strb[0]
			&& s_r.aw_addr[11:2] == 10'(`PCG_OFF_BWC)
			&& s_r.w_data[`PCG_BWC_XLD])
			s_nxt.crystal_loss_detect = 1'b1;
		if (!s_r.base_clock_select)
			s_nxt.crystal_loss_detect = 1'b0;

		// zero range kills the pll and deselects the vco
		if (s_nxt.vrs == 4'h0)
			s_nxt.base_clock_select = 1'b0;
		if (s_nxt.base_clock_select)
			s_nxt.on = 1'b1;

		// source switch: pause 3 edges of each clock, then swap
		s_nxt.xc_q = crystal_clock;
		s_nxt.vc_q = vco_clock;
		xc_edge = crystal_clock && !s_r.xc_q;
		vc_edge = vco_clock && !s_r.vc_q;
		s_nxt.div = s_r.div;
		case (s_r.sw)
		PCG_ST_RUN: begin
			if (s_r.base_clock_select != s_r.src_sel) begin
				s_nxt.sw = PCG_ST_XHLD;
				s_nxt.sw_cnt = 3'h0;
			end else if (s_r.src_sel ? vc_edge : xc_edge)
				s_nxt.div = !s_r.div;
		end
		PCG_ST_XHLD: begin
			if (xc_edge)
				s_nxt.sw_cnt = s_r.sw_cnt + 3'h1;
			if (s_r.sw_cnt == `PCG_SW_CYC || !crystal_active) begin
				s_nxt.sw = PCG_ST_VHLD;
				s_nxt.sw_cnt = 3'h0;
			end
		end
		PCG_ST_VHLD: begin
			if (vc_edge || !s_r.on)
				s_nxt.sw_cnt = s_r.sw_cnt + 3'h1;
			if (s_r.sw_cnt == `PCG_SW_CYC) begin
				s_nxt.sw = PCG_ST_RUN;
				s_nxt.src_sel = s_r.base_clock_select;
			end
		end
		default:
			s_nxt.sw = PCG_ST_RUN;
		endcase

		s_nxt.irq = s_nxt.flag && s_nxt.ie && s_nxt.auto_bw;

		// outputs taken from next state so every pin but the tied-off bresp and rresp leaves a flop
		s_nxt.awrdy = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wrdy = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arrdy = !s_nxt.rvalid;
		s_nxt.en = s_nxt.on && (s_nxt.vrs != 4'h0);
		s_nxt.ratio = pcg_mul_eff(s_nxt.mul);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_r <= '0;
			s_r.on <= 1'b1;
			s_r.mul <= `PCG_MUL_RST;
			s_r.vrs <= `PCG_VRS_RST;
			s_r.sw <= PCG_ST_RUN;
			s_r.awrdy <= 1'b1;
			s_r.wrdy <= 1'b1;
			s_r.arrdy <= 1'b1;
			s_r.en <= 1'b1;
			s_r.ratio <= `PCG_MUL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = s_r.awrdy;
	assign s_axi_wready = s_r.wrdy;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = 2'h0;
	assign s_axi_arready = s_r.arrdy;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = 2'h0;
	assign pll_enable = s_r.en;
	assign pll_auto_bw = s_r.auto_bw;
	assign pll_tracking = s_r.trk_man;
	assign feedback_ratio = s_r.ratio;
	assign vco_range_select = s_r.vrs;
	assign base_clock_out = s_r.div;
	assign lock_irq = s_r.irq;

	// assertions
	property p_ie_manual;
		@(posedge clock) disable iff (rst)
		!s_r.auto_bw |-> !s_r.ie;
	endproperty
	a_ie_manual: assert property (p_ie_manual)
		else $error("enable set in manual mode");

	property p_toggle_flag;
		@(posedge clock) disable iff (rst)
		(s_r.auto_bw && pll_lock_in != s_r.lock_q) |=> s_r.flag;
	endproperty
	a_toggle_flag: assert property (p_toggle_flag)
		else $error("lock toggle did not set flag");

	property p_irq;
		@(posedge clock) disable iff (rst)
		(s_r.flag && s_r.ie && s_r.auto_bw) |-> lock_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt missing");

	property p_read_clear;
		@(posedge clock) disable iff (rst)
		(rd_go && s_axi_araddr == `PCG_ADDR_CTL && s_r.lock_q == pll_lock_in)
		|=> !s_r.flag;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("read did not clear flag");

	property p_bcs_on;
		@(posedge clock) disable iff (rst)
		s_r.base_clock_select |-> s_r.on && s_r.vrs != 4'h0;
	endproperty
	a_bcs_on: assert property (p_bcs_on)
		else $error("select without power or range");

	property p_bcs_rise;
		@(posedge clock) disable iff (rst)
		$rose(s_r.base_clock_select) |-> $past(s_r.on);
	endproperty
	a_bcs_rise: assert property (p_bcs_rise)
		else $error("select rose from off state");

	property p_prg_lock;
		@(posedge clock) disable iff (rst)
		s_r.on |=> $stable({s_r.mul, s_r.vrs});
	endproperty
	a_prg_lock: assert property (p_prg_lock)
		else $error("programming changed while on");

	property p_xld_sel;
		@(posedge clock) disable iff (rst)
		!s_r.base_clock_select |=> !s_r.crystal_loss_detect;
	endproperty
	a_xld_sel: assert property (p_xld_sel)
		else $error("crystal loss without vco select");

	property p_hold;
		@(posedge clock) disable iff (rst)
		(s_r.sw != PCG_ST_RUN) |=> $stable(s_r.div);
	endproperty
	a_hold: assert property (p_hold)
		else $error("output moved during switch");

	property p_ratio;
		@(posedge clock) disable iff (rst)
		feedback_ratio != 4'h0;
	endproperty
	a_ratio: assert property (p_ratio)
		else $error("ratio zero");
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.svh"
module tb;
	logic        clock, rst, pll_lock_in, pll_track_in, crystal_active;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, crystal_clock, vco_clock;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        pll_enable, pll_auto_bw, pll_tracking;
	logic        base_clock_out, lock_irq;
	logic [3:0]  feedback_ratio, vco_range_select;
	int          miscompares, n_compared, cnt;

	pcg_regs dut_u (
		.clock(clock), .rst(rst),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .pll_lock_in(pll_lock_in),
		.pll_track_in(pll_track_in), .crystal_active(crystal_active),
		.crystal_clock(crystal_clock), .vco_clock(vco_clock),
		.pll_enable(pll_enable), .pll_auto_bw(pll_auto_bw),
		.pll_tracking(pll_tracking), .feedback_ratio(feedback_ratio),
		.vco_range_select(vco_range_select),
		.base_clock_out(base_clock_out), .lock_irq(lock_irq)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// slow sources: crystal period 6 cycles, vco period 4 cycles
	always @(posedge clock) begin
		cnt <= cnt + 1;
		crystal_clock <= (cnt % 6) < 3;
		vco_clock <= (cnt % 4) < 2;
	end

	task close_out;
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		int n;
		logic aw, w;
		begin
			@(posedge clock);
			n = 0;
			aw = 1'b0;
			w = 1'b0;
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h000000, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (!(aw && w) && n < 50) begin
				@(posedge clock);
				n++;
				if (!aw && s_axi_awready) begin
					aw = 1'b1;
					s_axi_awvalid <= 1'b0;
				end
				if (!w && s_axi_wready) begin
					w = 1'b1;
					s_axi_wvalid <= 1'b0;
				end
			end
			while (s_axi_bvalid !== 1'b1 && n < 100) begin
				@(posedge clock);
				n++;
			end
			s_axi_bready <= 1'b0;
			if (n >= 100)
				miscompares++;
			chk(s_axi_bresp, 32'h0);
		end
	endtask

	task rc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		int n;
		begin
			@(posedge clock);
			n = 0;
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do begin
				@(posedge clock);
				n++;
			end while (s_axi_arready !== 1'b1 && n < 50);
			s_axi_arvalid <= 1'b0;
			while (s_axi_rvalid !== 1'b1 && n < 100) begin
				@(posedge clock);
				n++;
			end
			s_axi_rready <= 1'b0;
			if (n >= 100)
				miscompares++;
			chk(s_axi_rdata & {24'hFFFFFF, m}, {24'h0, e & m});
			chk(s_axi_rresp, 32'h0);
		end
	endtask

	// count output rises over 240 cycles; allow one edge of phase slack
	task meas(input int e);
		int n;
		logic p;
		begin
			n = 0;
			p = base_clock_out;
			repeat (240) begin
				@(posedge clock);
				if (base_clock_out && !p)
					n++;
				p = base_clock_out;
			end
			chk(n >= e - 1 && n <= e + 1, 32'h1);
		end
	endtask

	initial begin
		#300000;
		miscompares++;
		close_out();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, pll_lock_in, pll_track_in} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		{miscompares, n_compared} = 0;
		crystal_active = 1'b1;
		rst = 1'b1;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		rc(`PCG_ADDR_CTL, 8'hFF, 8'h2F);
		rc(`PCG_ADDR_BWC, 8'hFF, 8'h00);
		rc(`PCG_ADDR_PRG, 8'hFF, 8'h66);
		rc(12'h100, 8'hFF, 8'h00);
		chk({feedback_ratio, vco_range_select}, 32'h66);
		chk(pll_enable, 32'h1);
		wr(`PCG_ADDR_PRG, 8'h35);
		rc(`PCG_ADDR_PRG, 8'hFF, 8'h66);
		meas(20);
		wr(`PCG_ADDR_CTL, 8'h30);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'h3F);
		repeat (40) @(posedge clock);
		meas(30);
		crystal_active <= 1'b0;
		wr(`PCG_ADDR_BWC, 8'h10);
		repeat (24) @(posedge clock);
		rc(`PCG_ADDR_BWC, 8'h10, 8'h10);
		crystal_active <= 1'b1;
		wr(`PCG_ADDR_BWC, 8'h10);
		repeat (24) @(posedge clock);
		rc(`PCG_ADDR_BWC, 8'h10, 8'h00);
		// power stays on while the select is being dropped
		wr(`PCG_ADDR_CTL, 8'h00);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'h2F);
		wr(`PCG_ADDR_CTL, 8'h00);
		wr(`PCG_ADDR_CTL, 8'h10);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'h0F);
		chk(pll_enable, 32'h0);
		wr(`PCG_ADDR_BWC, 8'h10);
		rc(`PCG_ADDR_BWC, 8'h10, 8'h00);
		wr(`PCG_ADDR_PRG, 8'h00);
		rc(`PCG_ADDR_PRG, 8'hFF, 8'h00);
		chk({feedback_ratio, vco_range_select}, 32'h10);
		wr(`PCG_ADDR_CTL, 8'h20);
		wr(`PCG_ADDR_CTL, 8'h30);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'h2F);
		chk(pll_enable, 32'h0);
		wr(`PCG_ADDR_CTL, 8'h00);
		wr(`PCG_ADDR_PRG, 8'h66);
		wr(`PCG_ADDR_BWC, 8'h20);
		rc(`PCG_ADDR_BWC, 8'hFF, 8'h20);
		wr(`PCG_ADDR_BWC, 8'hA0);
		rc(`PCG_ADDR_BWC, 8'hFF, 8'h80);
		chk(pll_auto_bw, 32'h1);
		pll_track_in <= 1'b1;
		rc(`PCG_ADDR_BWC, 8'hFF, 8'hA0);
		pll_track_in <= 1'b0;
		wr(`PCG_ADDR_BWC, 8'h00);
		rc(`PCG_ADDR_BWC, 8'hFF, 8'h20);
		chk(pll_tracking, 32'h1);
		wr(`PCG_ADDR_BWC, 8'h80);
		wr(`PCG_ADDR_CTL, 8'hA0);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'hAF);
		pll_lock_in <= 1'b1;
		repeat (5) @(posedge clock);
		chk(lock_irq, 32'h1);
		rc(`PCG_ADDR_BWC, 8'hFF, 8'hC0);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'hEF);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'hAF);
		chk(lock_irq, 32'h0);
		wr(`PCG_ADDR_CTL, 8'h20);
		pll_lock_in <= 1'b0;
		repeat (5) @(posedge clock);
		chk(lock_irq, 32'h0);
		pll_lock_in <= 1'b1;
		wr(`PCG_ADDR_BWC, 8'h00);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'h2F);
		rc(`PCG_ADDR_BWC, 8'hFF, 8'h00);
		wr(`PCG_ADDR_CTL, 8'hA0);
		rc(`PCG_ADDR_CTL, 8'hFF, 8'h2F);
		close_out();
	end
endmodule
`default_nettype wire
